/* File: hw/limit_irq_pkg.sv */
/*
  Constants and carrier types for the limit-check and interrupt block.
  Assumes one 125 MHz clock and a byte-wide register port.
*/
package limit_irq_pkg;
  // ********************************************************
  // Register offsets
  // ********************************************************
  localparam logic [3:0] OFS_X_LIMIT   = 4'h4;
  localparam logic [3:0] OFS_Y_LIMIT   = 4'h5;
  localparam logic [3:0] OFS_Z_LIMIT   = 4'h6;
  localparam logic [3:0] OFS_T_LIMIT   = 4'h7;
  localparam logic [3:0] OFS_IRQ_SETUP = 4'h8;
  localparam logic [7:0] REG_RESET     = 8'h00;
  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int BIT_TEMP_EN     = 0;
  localparam int BIT_RESULT_EN   = 7;
  localparam int BIT_CROSS_EN    = 6;
  localparam int BIT_PULSE_SEL   = 5;
  localparam int BIT_ROUTE_LO    = 2;
  localparam int BIT_PIN_DISABLE = 0;
  localparam logic [7:0] IRQ_SETUP_WMASK = 8'hFD;
  // ********************************************************
  // Route codes
  // ********************************************************
  localparam logic [2:0] ROUTE_NONE      = 3'h0;
  localparam logic [2:0] ROUTE_PIN       = 3'h1;
  localparam logic [2:0] ROUTE_PIN_IDLE  = 3'h2;
  localparam logic [2:0] ROUTE_SCL       = 3'h3;
  localparam logic [2:0] ROUTE_SCL_IDLE  = 3'h4;
  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_MHZ       = 125;
  localparam int PULSE_US      = 10;
  localparam int PULSE_CYCLES  = PULSE_US * CLK_MHZ;
  localparam logic [10:0] PULSE_LAST = 11'(PULSE_CYCLES - 1);
  localparam logic [2:0]  MULTI_CROSS = 3'h4;

  typedef struct packed {
    logic [7:0] x_code;
    logic [7:0] y_code;
    logic [7:0] z_code;
    logic [7:0] t_code;
  } sample_t;

  typedef enum logic [1:0] {IRQ_IDLE, IRQ_LATCHED, IRQ_PULSE} irq_state_t;
endpackage

/* File: hw/field_threshold_irq.sv */
/*
  Limit-check and interrupt block of a three-axis field sensor.
  Assumes the serial slave delivers byte writes/reads and bus status as
  same-clock signals; scaled field/temperature codes come from the converter.
*/
`timescale 1ns/1ps
module field_threshold_irq
  import limit_irq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data,
  input  wire logic       host_addressed,
  input  wire logic       bus_busy,
  input  wire logic       conv_done,
  input  wire sample_t    sample,
  input  wire logic       crossing_count_select,
  input  wire logic       crossing_direction_select,
  input  wire logic       planar_range,
  input  wire logic       vertical_range,
  output logic            temperature_channel_enable,
  output logic            alert_pin_out,
  output logic            alert_pin_oe,
  output logic            scl_pull_oe
);
  // ********************************************************
  // Registers
  // ********************************************************
  logic [7:0] x_limit_code_ff, y_limit_code_ff, z_limit_code_ff, t_cfg_ff, irq_setup_ff;
  logic [2:0] cross_cnt_ff;
  logic [10:0] pulse_cnt_ff;
  irq_state_t state_ff, nxt_state;

  function automatic logic over_limit(input logic [7:0] code, input logic [7:0] lim,
                                      input logic below);
    over_limit = below ? ($signed(code) < $signed(lim)) : ($signed(code) > $signed(lim));
  endfunction

  wire logic [6:0] temperature_limit_code = t_cfg_ff[7:1];
  wire logic result_irq_enable  = irq_setup_ff[BIT_RESULT_EN];
  wire logic crossing_irq_enable = irq_setup_ff[BIT_CROSS_EN];
  wire logic pulse_sel          = irq_setup_ff[BIT_PULSE_SEL];
  wire logic [2:0] route        = irq_setup_ff[BIT_ROUTE_LO +: 3];
  wire logic alert_pin_disable  = irq_setup_ff[BIT_PIN_DISABLE];

  // Range bits only rescale mT per code; comparison stays in code units
  wire logic range_ok = planar_range | ~planar_range | vertical_range;
  wire logic x_hit = (x_limit_code_ff != 8'h00) &&
                     over_limit(sample.x_code, x_limit_code_ff, crossing_direction_select);
  wire logic y_hit = (y_limit_code_ff != 8'h00) &&
                     over_limit(sample.y_code, y_limit_code_ff, crossing_direction_select);
  wire logic z_hit = (z_limit_code_ff != 8'h00) &&
                     over_limit(sample.z_code, z_limit_code_ff, crossing_direction_select);
  wire logic t_hit = t_cfg_ff[BIT_TEMP_EN] && (temperature_limit_code != 7'h00) &&
                     over_limit(sample.t_code, {1'b0, temperature_limit_code},
                                crossing_direction_select);
  wire logic crossing = conv_done && range_ok && (x_hit | y_hit | z_hit | t_hit);
  wire logic [2:0] need_cross = crossing_count_select ? MULTI_CROSS : 3'h1;
  wire logic cross_fire = crossing && ((cross_cnt_ff + 3'h1) >= need_cross);
  wire logic fire = (result_irq_enable && conv_done) ||
                    (crossing_irq_enable && cross_fire);
  wire logic pulse_end = (pulse_cnt_ff == PULSE_LAST);
  wire logic irq_active = (state_ff != IRQ_IDLE);
  // Busy-gated routes hold a latched event off the line until idle; a pulse that starts and ends while busy never reaches it
  wire logic route_pin = (route == ROUTE_PIN) || (route == ROUTE_PIN_IDLE && !bus_busy);
  wire logic route_scl = (route == ROUTE_SCL) || (route == ROUTE_SCL_IDLE && !bus_busy);

  // ********************************************************
  // Interrupt sequencing
  // ********************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      IRQ_IDLE: begin
        if (fire) begin
          nxt_state = pulse_sel ? IRQ_PULSE : IRQ_LATCHED;
        end
      end
      IRQ_LATCHED: begin
        if (host_addressed && !fire) begin
          nxt_state = IRQ_IDLE;
        end
      end
      IRQ_PULSE: begin
        if (pulse_end) begin
          nxt_state = IRQ_IDLE;
        end
      end
      default: nxt_state = IRQ_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_ff     <= IRQ_IDLE;
      pulse_cnt_ff <= 11'h000;
    end else begin
      state_ff     <= nxt_state;
      pulse_cnt_ff <= (state_ff == IRQ_PULSE && !pulse_end) ? pulse_cnt_ff + 11'h001 : 11'h000;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cross_cnt_ff <= 3'h0;
    end else if (cross_fire) begin
      cross_cnt_ff <= 3'h0;
    end else if (crossing) begin
      cross_cnt_ff <= cross_cnt_ff + 3'h1;
    end
  end

  // ********************************************************
  // Register port
  // ********************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      x_limit_code_ff <= REG_RESET;
      y_limit_code_ff <= REG_RESET;
      z_limit_code_ff <= REG_RESET;
      t_cfg_ff        <= REG_RESET;
      irq_setup_ff    <= REG_RESET;
    end else if (wr_en) begin
      case (reg_addr)
        OFS_X_LIMIT:   x_limit_code_ff <= wr_data;
        OFS_Y_LIMIT:   y_limit_code_ff <= wr_data;
        OFS_Z_LIMIT:   z_limit_code_ff <= wr_data;
        OFS_T_LIMIT:   t_cfg_ff        <= wr_data;
        OFS_IRQ_SETUP: irq_setup_ff    <= wr_data & IRQ_SETUP_WMASK;
        default: ;
      endcase
    end
  end

  wire logic [7:0] rd_mux = (reg_addr == OFS_X_LIMIT)   ? x_limit_code_ff :
                            (reg_addr == OFS_Y_LIMIT)   ? y_limit_code_ff :
                            (reg_addr == OFS_Z_LIMIT)   ? z_limit_code_ff :
                            (reg_addr == OFS_T_LIMIT)   ? t_cfg_ff :
                            (reg_addr == OFS_IRQ_SETUP) ? irq_setup_ff : 8'h00;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_data                    <= 8'h00;
      temperature_channel_enable <= 1'b0;
      alert_pin_out              <= 1'b1;
      alert_pin_oe               <= 1'b0;
      scl_pull_oe                <= 1'b0;
    end else begin
      rd_data                    <= rd_en ? rd_mux : rd_data;
      temperature_channel_enable <= t_cfg_ff[BIT_TEMP_EN];
      // Alert is active low open drain: drive low only while asserted
      alert_pin_out              <= 1'b0;
      alert_pin_oe               <= irq_active && route_pin && !alert_pin_disable;
      scl_pull_oe                <= irq_active && route_scl;
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  sequence pulse_start_s;
    state_ff == IRQ_IDLE && fire && pulse_sel;
  endsequence

  chk_pulse_length: assert property (@(posedge clk) disable iff (!reset_n)
    pulse_start_s |=> (state_ff == IRQ_PULSE) [*8])
    else $error("pulse state left too early");
  chk_pulse_end: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == IRQ_PULSE && pulse_end) |=> state_ff == IRQ_IDLE)
    else $error("pulse did not end");
  chk_latch_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == IRQ_LATCHED && !host_addressed) |=> state_ff == IRQ_LATCHED)
    else $error("latched interrupt dropped without host access");
  chk_latch_clear: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == IRQ_LATCHED && host_addressed && !fire) |=> state_ff == IRQ_IDLE)
    else $error("latched interrupt not cleared");
  chk_result_fire: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == IRQ_IDLE && conv_done && result_irq_enable) |=> irq_active)
    else $error("result interrupt missed");
  chk_no_fire: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == IRQ_IDLE && !fire) |=> !irq_active)
    else $error("spurious interrupt");
  chk_zero_limit: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == IRQ_IDLE && !result_irq_enable && x_limit_code_ff == 8'h00 &&
     y_limit_code_ff == 8'h00 && z_limit_code_ff == 8'h00 &&
     temperature_limit_code == 7'h00) |=> !irq_active)
    else $error("zero limit compared");
  chk_temp_gate: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == IRQ_IDLE && !result_irq_enable && !t_cfg_ff[BIT_TEMP_EN] &&
     x_limit_code_ff == 8'h00 && y_limit_code_ff == 8'h00 &&
     z_limit_code_ff == 8'h00) |=> !irq_active)
    else $error("temperature checked while disabled");
  chk_pin_mask: assert property (@(posedge clk) disable iff (!reset_n)
    alert_pin_disable |=> !alert_pin_oe)
    else $error("alert pin driven while disabled");
  chk_route_none: assert property (@(posedge clk) disable iff (!reset_n)
    (route == ROUTE_NONE) |=> !alert_pin_oe && !scl_pull_oe)
    else $error("interrupt routed with route none");
  chk_pin_drive: assert property (@(posedge clk) disable iff (!reset_n)
    (irq_active && route == ROUTE_PIN && !alert_pin_disable) |=> alert_pin_oe)
    else $error("pin route not driven");
  chk_scl_busy: assert property (@(posedge clk) disable iff (!reset_n)
    (irq_active && route == ROUTE_SCL_IDLE && bus_busy) |=> !scl_pull_oe)
    else $error("clock line pulled while bus busy");
endmodule

/* File: tb/host_model.sv */
/*
  Host-side model: byte register writes and reads, and address-phase pulses.
  Assumes the tasks are called from the bench between clock edges.
*/
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk,
  output logic            wr_en,
  output logic            rd_en,
  output logic      [3:0] reg_addr,
  output logic      [7:0] wr_data,
  output logic            host_addressed,
  input  wire logic [7:0] rd_data
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    reg_addr = 4'h0;
    wr_data = 8'h00;
    host_addressed = 1'b0;
  end
  // Scenarios here never issue reserved route codes on purpose
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    reg_addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // Read data is taken a full edge later so either update latency is safe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    #1 d = rd_data;
  endtask
  task automatic touch();
    @(posedge clk);
    host_addressed <= 1'b1;
    @(posedge clk);
    host_addressed <= 1'b0;
  endtask
endmodule

/* File: tb/tb_top.sv */
/*
  Self-checking bench for the limit-check and interrupt block.
  Assumes the host model drives the register port; range inputs are driven
  to show that they leave the code compare alone.
*/
`timescale 1ns/1ps
module tb_top
  import limit_irq_pkg::*;
;
  typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic clk = 0, reset_n = 0, conv_done = 0, bus_busy = 0, cnt_sel = 0, dir_sel = 0;
  logic prange = 0, vrange = 0;
  logic wr_en, rd_en, host_addressed, t_en, pin_out, pin_oe, scl_oe;
  logic [3:0] reg_addr;
  logic [7:0] wr_data, rd_data, rdv;
  sample_t sample = '0;
  int n_fail = 0, check_count = 0, k, n;
  row_t rows [6] = '{'{4'h4, 8'h80, 8'h80}, '{4'h5, 8'h7F, 8'h7F}, '{4'h6, 8'h01, 8'h01},
                     '{4'h7, 8'h35, 8'h35}, '{4'h8, 8'hF1, 8'hF1}, '{4'h3, 8'hAA, 8'h00}};
  always #4 clk = ~clk;
  host_model i_host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .reg_addr(reg_addr),
    .wr_data(wr_data), .host_addressed(host_addressed), .rd_data(rd_data));
  field_threshold_irq i_dut (.clk(clk), .reset_n(reset_n), .wr_en(wr_en), .rd_en(rd_en),
    .reg_addr(reg_addr), .wr_data(wr_data), .rd_data(rd_data),
    .host_addressed(host_addressed), .bus_busy(bus_busy), .conv_done(conv_done),
    .sample(sample), .crossing_count_select(cnt_sel), .crossing_direction_select(dir_sel),
    .planar_range(prange), .vertical_range(vrange), .temperature_channel_enable(t_en),
    .alert_pin_out(pin_out), .alert_pin_oe(pin_oe), .scl_pull_oe(scl_oe));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic conv(input logic [7:0] x, input logic [7:0] t);
    @(posedge clk);
    sample <= '{x_code: x, y_code: x, z_code: x, t_code: t};
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
  endtask
  // Looks for any high cycle of the chosen pull enable over lim cycles
  task automatic watch(input string nm, input bit s, input logic e, input int lim);
    logic got;
    got = 1'b0;
    for (int i = 0; i < lim; i++) begin
      @(posedge clk);
      #1 if ((s ? scl_oe : pin_oe) === 1'b1) got = 1'b1;
    end
    check(nm, {15'h0, got}, {15'h0, e});
  endtask
  task automatic clr();
    i_host.touch();
    repeat (4) @(posedge clk);
    #1 check("oe_cleared", {14'h0, pin_oe, scl_oe}, 16'h0);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge clk);
    check("pin_in_reset", {15'h0, pin_out}, 16'h1);
    reset_n <= 1'b1;
    for (k = 4; k <= 8; k++) begin
      i_host.rd(4'(k), rdv);
      check("reset_value", {8'h0, rdv}, 16'h0);
    end
    check("oe_after_reset", {12'h0, pin_out, t_en, pin_oe, scl_oe}, 16'h0);
    $display("test reset done");
    for (k = 0; k < 6; k++) begin
      i_host.wr(rows[k].a, rows[k].d);
      i_host.rd(rows[k].a, rdv);
      check("reg_rw", {8'h0, rdv}, {8'h0, rows[k].e});
    end
    check("temp_enable", {15'h0, t_en}, 16'h1);
    for (k = 4; k <= 7; k++) i_host.wr(4'(k), 8'h00);
    $display("test registers done");
    for (k = 0; k < 5; k++) begin
      i_host.wr(4'h8, 8'h80 | 8'(k << 2));
      conv(8'h00, 8'h00);
      watch("pin_route", 1'b0, (k == 1 || k == 2), 10);
      watch("scl_route", 1'b1, (k == 3 || k == 4), 10);
      repeat (20) @(posedge clk);
      #1 check("latched", {15'h0, pin_oe | scl_oe}, {15'h0, k != 0});
      clr();
    end
    bus_busy <= 1'b1;
    i_host.wr(4'h8, 8'h90);
    conv(8'h00, 8'h00);
    watch("scl_busy", 1'b1, 1'b0, 10);
    bus_busy <= 1'b0;
    watch("scl_idle", 1'b1, 1'b1, 10);
    clr();
    i_host.wr(4'h8, 8'h85);
    conv(8'h00, 8'h00);
    watch("pin_disabled", 1'b0, 1'b0, 10);
    clr();
    i_host.wr(4'h8, 8'hA4);
    conv(8'h00, 8'h00);
    #1 n = 0;
    for (k = 0; k < 10 && pin_oe !== 1'b1; k++) #8;
    for (k = 0; k < 2000 && pin_oe === 1'b1; k++) #8 n++;
    check("pulse_len", 16'(n), 16'(PULSE_CYCLES));
    $display("test routing done");
    prange <= 1'b1;
    vrange <= 1'b1;
    i_host.wr(4'h8, 8'h44);
    conv(8'h7F, 8'h00);
    watch("zero_limit", 1'b0, 1'b0, 10);
    i_host.wr(4'h4, 8'h10);
    conv(8'h20, 8'h00);
    watch("above", 1'b0, 1'b1, 10);
    clr();
    conv(8'h05, 8'h00);
    watch("not_above", 1'b0, 1'b0, 10);
    dir_sel <= 1'b1;
    conv(8'h05, 8'h00);
    watch("below", 1'b0, 1'b1, 10);
    clr();
    dir_sel <= 1'b0;
    i_host.wr(4'h4, 8'hF0);
    conv(8'h00, 8'h00);
    watch("signed_limit", 1'b0, 1'b1, 10);
    clr();
    i_host.wr(4'h4, 8'h00);
    for (k = 5; k <= 6; k++) begin
      i_host.wr(4'(k), 8'h10);
      conv(8'h20, 8'h00);
      watch("yz_limit", 1'b0, 1'b1, 10);
      clr();
      i_host.wr(4'(k), 8'h00);
    end
    i_host.wr(4'h7, 8'h35);
    conv(8'h00, 8'h20);
    watch("temp_hit", 1'b0, 1'b1, 10);
    clr();
    i_host.wr(4'h7, 8'h34);
    conv(8'h00, 8'h20);
    watch("temp_off", 1'b0, 1'b0, 10);
    i_host.wr(4'h7, 8'h00);
    i_host.wr(4'h4, 8'h10);
    cnt_sel <= 1'b1;
    repeat (3) conv(8'h20, 8'h00);
    watch("three_hits", 1'b0, 1'b0, 10);
    conv(8'h20, 8'h00);
    watch("fourth_hit", 1'b0, 1'b1, 10);
    clr();
    $display("test crossing done");
    i_host.wr(4'h8, 8'h84);
    conv(8'h00, 8'h00);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    i_host.rd(4'h8, rdv);
    check("mid_reset", {7'h0, rdv, pin_oe}, 16'h0);
    $display("test mid reset done");
    end_sim();
  end
endmodule
